// ### common/branch_skip_pkg.sv
// shared constants, types and helpers of the branch and skip unit
package branch_skip_pkg;
  localparam logic [7:0] OP_BRANCH_IF_ZERO = 8'he0;
  localparam logic [7:0] OP_DECREMENT_ONE_BRANCH = 8'he6;
  localparam logic [7:0] OP_DECREMENT_TWO_BRANCH = 8'he7;
  localparam logic [7:0] OP_BRANCH_SAVE_RETURN = 8'hea;
  localparam logic [7:0] OP_SKIP_BACK_ALWAYS = 8'h4e;
  localparam logic [7:0] OP_SKIP_FORWARD_ALWAYS = 8'h4f;
  localparam logic [7:0] OP_SKIP_BACK_IF_FLAG_CLEAR = 8'h4b;
  localparam logic [7:0] OP_SKIP_FORWARD_IF_FLAG_CLEAR = 8'h49;

  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_INSTRUCTION = 5'h04;
  localparam logic [4:0] REG_BASE_TARGET = 5'h08;
  localparam logic [4:0] REG_PROGRAM_ADDR = 5'h0c;
  localparam logic [4:0] REG_CONDITION = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_GPR_SELECT = 5'h18;
  localparam logic [4:0] REG_GPR_DATA = 5'h1c;

  localparam int CTRL_START_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_TAKEN_BIT = 2;
  localparam int STATUS_ILLEGAL_BIT = 3;
  localparam logic [3:0] COND_EQUAL_POS = 4'h3;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] ONE_WORD_BYTES = 16'h0002;
  localparam logic [15:0] TWO_WORD_BYTES = 16'h0004;
  localparam logic [15:0] DECREMENT_ONE = 16'h0001;
  localparam logic [15:0] DECREMENT_TWO = 16'h0002;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_TGT_IDX = 8'h02,
    ST_TGT_MEM = 8'h04,
    ST_OPR = 8'h08,
    ST_OPR_MEM = 8'h10,
    ST_EXEC = 8'h20,
    ST_WB_REG = 8'h40,
    ST_WB_MEM = 8'h80
  } state_e;

  // 16-bit wraparound add
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    add16 = a + b;
  endfunction

  // bit positions count from the msb: position 0 is bit 15
  function automatic logic cond_bit(input logic [15:0] cond, input logic [3:0] pos);
    cond_bit = cond[4'hf - pos];
  endfunction

  // word count doubled into bytes, applied forward or back
  function automatic logic [15:0] skip_target(input logic [15:0] pc, input logic [7:0] count,
                                              input logic back);
    logic [15:0] bytes;
    bytes = {7'h00, count, 1'b0};
    skip_target = back ? pc - bytes : pc + bytes;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
endpackage

// ### logic/gpr_file.sv
// eight 16-bit general registers, one write port, registered read
`timescale 1ns/1ps
module gpr_file
  import branch_skip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [2:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [8];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= WORD_RESET;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule

// ### logic/skip_resolver.sv
// decodes the one-word skip group and forms its next program address
`timescale 1ns/1ps
module skip_resolver
  import branch_skip_pkg::*;
(
  input wire logic [15:0] instr,
  input wire logic [15:0] pc,
  input wire logic [15:0] cond,
  output logic is_skip,
  output logic jump,
  output logic [15:0] next_pc
);
  logic back;
  logic [7:0] count;

  always_comb begin
    is_skip = 1'b1;
    jump = 1'b0;
    back = 1'b0;
    count = 8'h00;
    case (instr[15:8])
      OP_SKIP_BACK_ALWAYS: begin
        jump = 1'b1;
        back = 1'b1;
        count = instr[7:0];
      end
      OP_SKIP_FORWARD_ALWAYS: begin
        jump = 1'b1;
        count = instr[7:0];
      end
      OP_SKIP_BACK_IF_FLAG_CLEAR: begin
        jump = !cond_bit(cond, instr[3:0]);
        back = 1'b1;
        count = {4'h0, instr[7:4]};
      end
      OP_SKIP_FORWARD_IF_FLAG_CLEAR: begin
        jump = !cond_bit(cond, instr[3:0]);
        count = {4'h0, instr[7:4]};
      end
      default: begin
        is_skip = 1'b0;
      end
    endcase
    next_pc = jump ? skip_target(pc, count, back) : add16(pc, ONE_WORD_BYTES);
  end
endmodule

// ### logic/branch_skip_unit.sv
// branch and skip execution unit with avalon register access
//
// Operation
// - zero-test branch jumps when operand is all zero, else next instruction
// - tested operand is a 16-bit word from register or storage via register
// - zero-test branch goes to target exactly when tested operand is zero
// - decrement-one: zero falls through; else subtract one, write back, jump
// - decrement-two: zero falls through; else subtract two, write back, jump
// - indirect decrement updates storage word addressed by the register
// - target is base word, optionally indexed by first register, optionally indirect
// - save-return always jumps and saves program address plus four
// - return address goes to second register, or storage it points to
// - skip back subtracts doubled 8-bit count in bits 0-7 from program address
// - skip forward adds doubled 8-bit count to program address
// - every skip doubles its word count into bytes
// - flag-clear skip back moves back when flag clear, else next instruction
// - condition skips: count in bits 4-7, flag index in bits 0-3
// - condition position 3 is the equal indication
`timescale 1ns/1ps
module branch_skip_unit
  import branch_skip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [15:0] program_addr,
  output logic equal_flag
);
  logic [15:0] instr_q, base_q, pc_q, cond_q;
  logic [15:0] tgt_q, opnd_q, ptr_q, wval_q;
  logic [2:0] sel_q;
  logic start_q, done_q, taken_q, illegal_q, resp_q;
  logic [31:0] rdata_q;
  state_e st_q;

  logic [7:0] opcode;
  logic tgt_ind, r2_ind, busy, bus_req, bus_wr, bus_rd_setup, is_branch, opnd_zero;
  logic [2:0] r1, r2, gpr_raddr, gpr_waddr;
  logic [15:0] gpr_rdata, gpr_wdata, skip_pc, dec_amount;
  logic skip_hit, skip_jump, gpr_we, finish;

  assign opcode = instr_q[15:8];
  assign tgt_ind = instr_q[7];
  assign r1 = instr_q[6:4];
  assign r2_ind = instr_q[3];
  assign r2 = instr_q[2:0];
  assign is_branch = (opcode == OP_BRANCH_IF_ZERO) || (opcode == OP_DECREMENT_ONE_BRANCH) ||
                     (opcode == OP_DECREMENT_TWO_BRANCH) || (opcode == OP_BRANCH_SAVE_RETURN);
  assign opnd_zero = (opnd_q == WORD_RESET);
  assign dec_amount = (opcode == OP_DECREMENT_TWO_BRANCH) ? DECREMENT_TWO : DECREMENT_ONE;
  assign busy = start_q || (st_q != ST_IDLE);

  skip_resolver u_skip (
    .instr(instr_q),
    .pc(pc_q),
    .cond(cond_q),
    .is_skip(skip_hit),
    .jump(skip_jump),
    .next_pc(skip_pc)
  );

  // bus: one wait cycle, then the access completes
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !resp_q;
  assign bus_wr = avs_write && resp_q;
  assign bus_rd_setup = avs_read && !resp_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= bus_req && !resp_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_rd_setup) begin
      case (avs_address)
        REG_INSTRUCTION: rdata_q <= {16'h0000, instr_q};
        REG_BASE_TARGET: rdata_q <= {16'h0000, base_q};
        REG_PROGRAM_ADDR: rdata_q <= {16'h0000, pc_q};
        REG_CONDITION: rdata_q <= {16'h0000, cond_q};
        REG_STATUS: rdata_q <= {28'h0000000, illegal_q, taken_q, done_q, busy};
        REG_GPR_SELECT: rdata_q <= {29'h00000000, sel_q};
        REG_GPR_DATA: rdata_q <= {16'h0000, gpr_rdata};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes are ignored while an instruction runs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      instr_q <= WORD_RESET;
      base_q <= WORD_RESET;
      cond_q <= WORD_RESET;
      sel_q <= 3'h0;
    end else if (bus_wr && !busy) begin
      case (avs_address)
        REG_INSTRUCTION: instr_q <= merge16(instr_q, avs_writedata, avs_byteenable);
        REG_BASE_TARGET: base_q <= merge16(base_q, avs_writedata, avs_byteenable);
        REG_CONDITION: cond_q <= merge16(cond_q, avs_writedata, avs_byteenable);
        REG_GPR_SELECT: begin
          if (avs_byteenable[0]) begin
            sel_q <= avs_writedata[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= bus_wr && !busy && (avs_address == REG_CONTROL) && avs_byteenable[0] &&
                 avs_writedata[CTRL_START_BIT];
    end
  end

  // register file: index/operand reads during execution, bus access when idle
  assign gpr_raddr = (st_q == ST_IDLE) ? (start_q ? r1 : sel_q) : r2;
  assign gpr_we = (st_q == ST_WB_REG) || (bus_wr && !busy && (avs_address == REG_GPR_DATA));
  assign gpr_waddr = (st_q == ST_WB_REG) ? r2 : sel_q;
  assign gpr_wdata = (st_q == ST_WB_REG) ? wval_q : merge16(gpr_rdata, avs_writedata,
                                                             avs_byteenable);

  gpr_file u_gpr (
    .clk(clk),
    .rst_b(rst_b),
    .we(gpr_we),
    .waddr(gpr_waddr),
    .wdata(gpr_wdata),
    .raddr(gpr_raddr),
    .rdata(gpr_rdata)
  );

  // storage port
  assign mem_req = (st_q == ST_TGT_MEM) || (st_q == ST_OPR_MEM) || (st_q == ST_WB_MEM);
  assign mem_we = (st_q == ST_WB_MEM);
  assign mem_addr = (st_q == ST_TGT_MEM) ? tgt_q : ptr_q;
  assign mem_wdata = wval_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_q && !skip_hit && is_branch) begin
            st_q <= ST_TGT_IDX;
          end
        end
        ST_TGT_IDX: st_q <= tgt_ind ? ST_TGT_MEM : ST_OPR;
        ST_TGT_MEM: begin
          if (mem_ack) begin
            st_q <= ST_OPR;
          end
        end
        ST_OPR: begin
          if (opcode == OP_BRANCH_SAVE_RETURN) begin
            st_q <= r2_ind ? ST_WB_MEM : ST_WB_REG;
          end else begin
            st_q <= r2_ind ? ST_OPR_MEM : ST_EXEC;
          end
        end
        ST_OPR_MEM: begin
          if (mem_ack) begin
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if ((opcode == OP_BRANCH_IF_ZERO) || opnd_zero) begin
            st_q <= ST_IDLE;
          end else begin
            st_q <= r2_ind ? ST_WB_MEM : ST_WB_REG;
          end
        end
        ST_WB_REG: st_q <= ST_IDLE;
        ST_WB_MEM: begin
          if (mem_ack) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgt_q <= WORD_RESET;
      ptr_q <= WORD_RESET;
      opnd_q <= WORD_RESET;
      wval_q <= WORD_RESET;
    end else begin
      if (st_q == ST_TGT_IDX) begin
        tgt_q <= add16(base_q, (r1 != 3'h0) ? gpr_rdata : WORD_RESET);
      end else if ((st_q == ST_TGT_MEM) && mem_ack) begin
        tgt_q <= mem_rdata;
      end
      if (st_q == ST_OPR) begin
        ptr_q <= gpr_rdata;
        opnd_q <= gpr_rdata;
      end else if ((st_q == ST_OPR_MEM) && mem_ack) begin
        opnd_q <= mem_rdata;
      end
      if ((st_q == ST_OPR) && (opcode == OP_BRANCH_SAVE_RETURN)) begin
        wval_q <= add16(pc_q, TWO_WORD_BYTES);
      end else if (st_q == ST_EXEC) begin
        wval_q <= opnd_q - dec_amount;
      end
    end
  end

  assign finish = (start_q && (st_q == ST_IDLE) && !is_branch) ||
                  ((st_q == ST_EXEC) && ((opcode == OP_BRANCH_IF_ZERO) || opnd_zero)) ||
                  (st_q == ST_WB_REG) || ((st_q == ST_WB_MEM) && mem_ack);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc_q <= WORD_RESET;
      taken_q <= 1'b0;
    end else if (bus_wr && !busy && (avs_address == REG_PROGRAM_ADDR)) begin
      pc_q <= merge16(pc_q, avs_writedata, avs_byteenable);
    end else if (start_q && (st_q == ST_IDLE) && skip_hit) begin
      pc_q <= skip_pc;
      taken_q <= skip_jump;
    end else if (start_q && (st_q == ST_IDLE)) begin
      // no stale taken flag survives into a new instruction
      taken_q <= 1'b0;
    end else if ((st_q == ST_OPR) && (opcode == OP_BRANCH_SAVE_RETURN)) begin
      pc_q <= tgt_q;
      taken_q <= 1'b1;
    end else if (st_q == ST_EXEC) begin
      if (opcode == OP_BRANCH_IF_ZERO) begin
        pc_q <= opnd_zero ? tgt_q : add16(pc_q, TWO_WORD_BYTES);
        taken_q <= opnd_zero;
      end else begin
        pc_q <= opnd_zero ? add16(pc_q, TWO_WORD_BYTES) : tgt_q;
        taken_q <= !opnd_zero;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
      illegal_q <= start_q && !skip_hit && !is_branch;
    end else if (start_q) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end
  end

  assign program_addr = pc_q;
  assign equal_flag = cond_bit(cond_q, COND_EQUAL_POS);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_exec_zero_test;
    (st_q == ST_EXEC) && (opcode == OP_BRANCH_IF_ZERO);
  endsequence

  sequence s_dec_nonzero;
    (st_q == ST_EXEC) && (opcode != OP_BRANCH_IF_ZERO) && !opnd_zero;
  endsequence

  chk_zero_test_target: assert property (
    s_exec_zero_test |=> (pc_q == ($past(opnd_zero) ? $past(tgt_q) : 16'($past(pc_q) + 16'h4))))
    else $error("zero-test branch formed a wrong program address");

  chk_decrement_value: assert property (
    s_dec_nonzero |=> (wval_q == 16'($past(opnd_q) -
      (($past(opcode) == OP_DECREMENT_TWO_BRANCH) ? 16'h2 : 16'h1))) && (pc_q == $past(tgt_q)))
    else $error("decrement branch wrote a wrong value or missed the target");

  chk_decrement_zero_falls: assert property (
    ((st_q == ST_EXEC) && (opcode != OP_BRANCH_IF_ZERO) && opnd_zero) |=>
      (pc_q == 16'($past(pc_q) + 16'h4)) && (st_q == ST_IDLE))
    else $error("zero operand did not fall through");

  chk_indirect_writeback: assert property (
    (st_q == ST_WB_MEM) |-> mem_req && mem_we && (mem_addr == ptr_q) && !gpr_we)
    else $error("indirect write-back not aimed at the pointed storage word");

  chk_direct_writeback: assert property (
    (st_q == ST_WB_REG) |-> gpr_we && (gpr_waddr == r2) && (gpr_wdata == wval_q))
    else $error("direct write-back not aimed at the second register");

  chk_return_address: assert property (
    ((st_q == ST_OPR) && (opcode == OP_BRANCH_SAVE_RETURN)) |=>
      (wval_q == 16'($past(pc_q) + 16'h4)) && (pc_q == $past(tgt_q)) && taken_q)
    else $error("save-return did not jump or saved a wrong address");

  chk_index_target: assert property (
    (st_q == ST_TGT_IDX) |=>
      (tgt_q == 16'($past(base_q) + (($past(r1) != 3'h0) ? $past(gpr_rdata) : 16'h0))))
    else $error("target not formed from base and index");

  chk_skip_always_back: assert property (
    (start_q && (st_q == ST_IDLE) && (opcode == OP_SKIP_BACK_ALWAYS)) |=>
      (pc_q == 16'($past(pc_q) - {7'h00, $past(instr_q[7:0]), 1'b0})))
    else $error("skip back moved by a wrong distance");

  chk_skip_always_fwd: assert property (
    (start_q && (st_q == ST_IDLE) && (opcode == OP_SKIP_FORWARD_ALWAYS)) |=>
      (pc_q == 16'($past(pc_q) + {7'h00, $past(instr_q[7:0]), 1'b0})))
    else $error("skip forward moved by a wrong distance");

  chk_flag_skip_back: assert property (
    (start_q && (st_q == ST_IDLE) && (opcode == OP_SKIP_BACK_IF_FLAG_CLEAR)) |=>
      (pc_q == ($past(cond_q[4'hf - instr_q[3:0]]) ? 16'($past(pc_q) + 16'h2) :
        16'($past(pc_q) - {11'h000, $past(instr_q[7:4]), 1'b0}))))
    else $error("flag-clear skip back formed a wrong address");

  chk_equal_flag: assert property (
    equal_flag == cond_q[12])
    else $error("equal indication not at condition position 3");

  chk_storage_hold: assert property (
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("storage request dropped or changed before its answer");

  chk_bus_answer: assert property (
    (bus_req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
endmodule

// ### bench/storage_model.sv
// main storage model answering the unit's word requests after a set delay
`timescale 1ns/1ps
module storage_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] mem_delay,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;

  // read data is only meaningful at the ack edge; it toggles otherwise
  always @(posedge clk) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_q >= mem_delay) begin
      mem_ack <= 1'b1;
      wait_q <= 4'h0;
      mem_rdata <= mem_we ? ~mem_wdata : mem[mem_addr[7:0]];
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// ### bench/branch_skip_unit_bench.sv
// register-level tests of the branch and skip unit
`timescale 1ns/1ps
module branch_skip_unit_bench;
  import branch_skip_pkg::*;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, mem_delay;
  logic mem_req, mem_we, mem_ack, equal_flag;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, program_addr;
  int fail_count, tests_run;

  branch_skip_unit u_branch_skip_unit (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .program_addr(program_addr), .equal_flag(equal_flag));
  storage_model u_storage_model (.clk(clk), .rst_b(rst_b), .mem_delay(mem_delay),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #10 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_bit(input string name, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic timeout(input string name);
    fail_count++;
    $display("ERROR %s expected completion seen timeout", name);
    report_and_stop();
  endtask

  // waitrequest is sampled at each rising edge; the transfer ends at the first low sample
  task automatic bus_wait();
    int n;
    n = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        timeout("avs_waitrequest");
      end
      @(posedge clk);
    end
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic gpr_set(input logic [2:0] r, input logic [15:0] v);
    bus_write(REG_GPR_SELECT, {13'h0000, r});
    bus_write(REG_GPR_DATA, v);
  endtask

  task automatic gpr_check(input logic [2:0] r, input logic [15:0] e);
    bus_write(REG_GPR_SELECT, {13'h0000, r});
    bus_read(REG_GPR_DATA, rd);
    check_word("general register", e, rd[15:0]);
  endtask

  // load both instruction words and the address, start, poll done, compare the new address
  task automatic run(input logic [15:0] ins, input logic [15:0] base, input logic [15:0] pc,
                     input logic [15:0] e);
    int n;
    bus_write(REG_INSTRUCTION, ins);
    bus_write(REG_BASE_TARGET, base);
    bus_write(REG_PROGRAM_ADDR, pc);
    bus_write(REG_CONTROL, 16'h0001);
    n = 0;
    rd = 32'h00000000;
    while (rd[STATUS_DONE_BIT] !== 1'b1) begin
      n++;
      if (n > 40) begin
        timeout("status done");
      end
      bus_read(REG_STATUS, rd);
    end
    check_word("program_addr", e, program_addr);
  endtask

  // low instruction byte: target indirect, index reg, operand indirect, operand reg
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    mem_delay = 4'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    check_word("program_addr after reset", 16'h0000, program_addr);
    bus_read(5'h02, rd);
    check_word("unmapped read", 16'h0000, rd[15:0]);
    $display("test reset done");
    gpr_set(3'h6, 16'h0000);
    run({OP_BRANCH_IF_ZERO, 8'h06}, 16'h0300, 16'h0100, 16'h0300);
    gpr_set(3'h6, 16'h8000);
    run({OP_BRANCH_IF_ZERO, 8'h06}, 16'h0300, 16'h0100, 16'h0104);
    check_bit("taken", 1'b0, rd[STATUS_TAKEN_BIT]);
    gpr_set(3'h1, 16'h0003);
    gpr_set(3'h6, 16'h0000);
    u_storage_model.mem[8'h23] = 16'h0500;
    mem_delay <= 4'h3;
    run({OP_BRANCH_IF_ZERO, 8'h96}, 16'h0020, 16'h0100, 16'h0500);
    run({OP_BRANCH_IF_ZERO, 8'h16}, 16'h0020, 16'h0100, 16'h0023);
    u_storage_model.mem[8'h44] = 16'h0000;
    gpr_set(3'h4, 16'h0044);
    run({OP_BRANCH_IF_ZERO, 8'h0c}, 16'h0300, 16'h0100, 16'h0300);
    $display("test zero branch done");
    gpr_set(3'h2, 16'h0005);
    run({OP_DECREMENT_ONE_BRANCH, 8'h02}, 16'h0400, 16'h0100, 16'h0400);
    gpr_check(3'h2, 16'h0004);
    gpr_set(3'h2, 16'h0000);
    run({OP_DECREMENT_ONE_BRANCH, 8'h02}, 16'h0400, 16'h0100, 16'h0104);
    gpr_check(3'h2, 16'h0000);
    gpr_set(3'h3, 16'h0040);
    u_storage_model.mem[8'h40] = 16'h0001;
    mem_delay <= 4'h0;
    run({OP_DECREMENT_TWO_BRANCH, 8'h0b}, 16'h0600, 16'h0100, 16'h0600);
    check_word("storage word", 16'hffff, u_storage_model.mem[8'h40]);
    gpr_check(3'h3, 16'h0040);
    u_storage_model.mem[8'h40] = 16'h0000;
    run({OP_DECREMENT_TWO_BRANCH, 8'h0b}, 16'h0600, 16'h0100, 16'h0104);
    check_word("storage word", 16'h0000, u_storage_model.mem[8'h40]);
    $display("test decrement branch done");
    gpr_set(3'h5, 16'h1234);
    run({OP_BRANCH_SAVE_RETURN, 8'h05}, 16'h0700, 16'hfffe, 16'h0700);
    check_bit("taken", 1'b1, rd[STATUS_TAKEN_BIT]);
    gpr_check(3'h5, 16'h0002);
    gpr_set(3'h5, 16'h0050);
    mem_delay <= 4'h2;
    run({OP_BRANCH_SAVE_RETURN, 8'h0d}, 16'h0700, 16'h1000, 16'h0700);
    check_word("return word", 16'h1004, u_storage_model.mem[8'h50]);
    $display("test save return done");
    run({OP_SKIP_BACK_ALWAYS, 8'h3e}, 16'h0000, 16'h0200, 16'h0184);
    check_bit("illegal", 1'b0, rd[STATUS_ILLEGAL_BIT]);
    run({OP_SKIP_BACK_ALWAYS, 8'hff}, 16'h0000, 16'h0100, 16'hff02);
    run({OP_SKIP_FORWARD_ALWAYS, 8'h08}, 16'h0000, 16'h0100, 16'h0110);
    run({OP_SKIP_FORWARD_ALWAYS, 8'hff}, 16'h0000, 16'hff00, 16'h00fe);
    $display("test skip done");
    bus_write(REG_CONDITION, 16'h0000);
    @(posedge clk);
    check_bit("equal_flag", 1'b0, equal_flag);
    run({OP_SKIP_BACK_IF_FLAG_CLEAR, 8'hc3}, 16'h0000, 16'h0300, 16'h02e8);
    run({OP_SKIP_FORWARD_IF_FLAG_CLEAR, 8'h53}, 16'h0000, 16'h0300, 16'h030a);
    bus_write(REG_CONDITION, 16'h1000);
    @(posedge clk);
    check_bit("equal_flag", 1'b1, equal_flag);
    run({OP_SKIP_BACK_IF_FLAG_CLEAR, 8'hc3}, 16'h0000, 16'h0300, 16'h0302);
    run({OP_SKIP_FORWARD_IF_FLAG_CLEAR, 8'h53}, 16'h0000, 16'h0300, 16'h0302);
    run({OP_SKIP_BACK_IF_FLAG_CLEAR, 8'hff}, 16'h0000, 16'h0300, 16'h02e2);
    run(16'h0000, 16'h0000, 16'h0300, 16'h0300);
    check_bit("illegal", 1'b1, rd[STATUS_ILLEGAL_BIT]);
    check_bit("taken", 1'b0, rd[STATUS_TAKEN_BIT]);
    $display("test condition skip done");
    report_and_stop();
  end
endmodule
